// [dv/acr_testbench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("wrong value t=%0t got=%0h exp=%0h", $time, a, b); end end

module testbench;
  import acr_pkg::*;
  // ==================================================
  // signals
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        global_highpass_setting_i = 1'b0;
  acr_cfg_t    chan_cfg_o;
  logic        chan_highpass_en_o;
  acr_cal_t    chan_cal_o;
  logic [31:0] exp_q[$];
  logic [31:0] got;
  logic [31:0] exp_v;
  logic [3:0]  be = 4'hF;
  logic [3:0]  avs_byteenable_i = 4'hF;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [15:0] d;
  logic [23:0] o;
  logic [23:0] g;
  logic        gl;

  acr_chan_regs uut (
    .ref_clk_i                (ref_clk_i),
    .rst_i                    (rst_i),
    .avs_address_i            (avs_address_i),
    .avs_read_i               (avs_read_i),
    .avs_write_i              (avs_write_i),
    .avs_writedata_i          (avs_writedata_i),
    .avs_byteenable_i         (avs_byteenable_i),
    .avs_readdata_o           (avs_readdata_o),
    .avs_waitrequest_o        (avs_waitrequest_o),
    .global_highpass_setting_i(global_highpass_setting_i),
    .chan_cfg_o               (chan_cfg_o),
    .chan_highpass_en_o       (chan_highpass_en_o),
    .chan_cal_o               (chan_cal_o)
  );

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ==================================================
  // bus master: hold until waitrequest sampled low
  task bus(input logic [7:0] a, input logic w, input logic [15:0] wd);
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_read_i      <= !w;
    avs_write_i     <= w;
    avs_writedata_i <= {16'h0000, wd};
    avs_byteenable_i <= be;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    // outputs are looked at once settled, away from the launching edge
    @(negedge ref_clk_i);
  endtask : bus

  task rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    bus(a, 1'b0, 16'h0000);
  endtask : rd

  task finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ==================================================
  // read monitor: oldest note against read data
  always @(posedge ref_clk_i) begin
    if (!rst_i && avs_read_i && avs_waitrequest_o === 1'b0) begin
      got = avs_readdata_o;
      if (exp_q.size() == 0) begin
        failures++;
      end else begin
        exp_v = exp_q.pop_front();
        `CHK(got, exp_v)
      end
    end
  end

  // hang guard, tests need well under 2000 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h0f30));
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // reset values
    rd(8'h9C, 16'h0000);
    rd(8'hA0, 16'h0000);
    rd(8'hA4, 16'h0000);
    rd(8'hA8, 16'h8000);
    rd(8'hAC, 16'h0000);
    `CHK(chan_cal_o.gain, 24'h800000)
    $display("test reset values done");
    // reserved bits drop writes
    bus(8'h9C, 1'b1, 16'hFFFF);
    rd(8'h9C, 16'hFFC7);
    bus(8'hA4, 1'b1, 16'hFFFF);
    rd(8'hA4, 16'hFF00);
    bus(8'hAC, 1'b1, 16'hFFFF);
    rd(8'hAC, 16'hFF00);
    $display("test reserved bits done");
    // every input mode, random trim and override
    for (int i = 0; i < 4; i++) begin
      d      = 16'($urandom);
      d[1:0] = 2'(i);
      gl     = 1'($urandom);
      global_highpass_setting_i <= gl;
      bus(8'h9C, 1'b1, d);
      rd(8'h9C, d & 16'hFFC7);
      `CHK(chan_cfg_o.chan_phase_trim, d[15:6])
      `CHK(chan_cfg_o.chan_input_select, acr_sel_t'(d[1:0]))
      `CHK(chan_cfg_o.chan_highpass_override, d[2])
      `CHK(chan_highpass_en_o, gl & ~d[2])
    end
    $display("test config modes done");
    // calibration words joined into 24-bit values
    o = 24'($urandom);
    g = 24'($urandom);
    bus(8'hA0, 1'b1, o[23:8]);
    bus(8'hA4, 1'b1, {o[7:0], 8'($urandom)});
    bus(8'hA8, 1'b1, g[23:8]);
    bus(8'hAC, 1'b1, {g[7:0], 8'($urandom)});
    `CHK(chan_cal_o.offset, o)
    `CHK(chan_cal_o.gain, g)
    rd(8'hA4, {o[7:0], 8'h00});
    rd(8'hAC, {g[7:0], 8'h00});
    rd(8'hA0, o[23:8]);
    rd(8'hA8, g[23:8]);
    // byte enables: only the enabled byte lands
    be = 4'h2;
    bus(8'hA0, 1'b1, 16'hA5C3);
    be = 4'h1;
    bus(8'hAC, 1'b1, 16'h5AFF);
    be = 4'hF;
    o[23:16] = 8'hA5;
    rd(8'hA0, o[23:8]);
    rd(8'hAC, {g[7:0], 8'h00});
    `CHK(chan_cal_o.offset, o)
    $display("test calibration done");
    // unmapped and unaligned places
    bus(8'hB0, 1'b1, 16'hFFFF);
    bus(8'hA2, 1'b1, 16'h1234);
    rd(8'hB0, 16'h0000);
    rd(8'hA2, 16'h0000);
    `CHK(chan_cal_o.offset, o)
    `CHK(chan_cal_o.gain, g)
    $display("test unmapped done");
    repeat (2) @(posedge ref_clk_i);
    if (exp_q.size() != 0) begin
      failures++;
    end
    finish_test();
  end
endmodule : testbench

// [src/acr_chan_regs.sv]
`timescale 1ns/1ps
`include "acr_regs_map.svh"

// Function
// - Config bits 15:6 hold the 10-bit two's complement phase trim in modulator cycles.
// - Config bits 5:3 are reserved and read as zero.
// - Config bit 2 at 0 leaves highpass to the global setting, at 1 disables it here.
// - Config bits 1:0 pick pins, shorted, positive test or negative test input.
// - The upper offset word holds bits 23:8 of the signed offset value.
// - The lower offset word holds offset bits 7:0 in its bits 15:8.
// - The upper gain word holds bits 23:8 of the unsigned gain value below 2.0.
// - The lower gain word holds gain bits 7:0 in its bits 15:8.
// - The upper gain word sits at 2Ah and resets to 8000h for unity gain.
// - Bits 7:0 of both lower words are reserved and read as zero.
// - The config word sits at 27h and resets to 0000h.
// - The upper offset word sits at 28h and resets to 0000h.
// - The lower offset word sits at 29h and lower gain at 2Bh, both reset 0000h.
module acr_chan_regs
  import acr_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // channel controls
  input  wire logic        global_highpass_setting_i,
  output acr_cfg_t         chan_cfg_o,
  output logic             chan_highpass_en_o,
  output acr_cal_t         chan_cal_o
);

  // ==================================================
  // decode
  localparam int NREG = 5;
  logic [5:0]  idx;
  logic        aligned;
  logic [NREG-1:0] hit;
  logic [15:0] q [NREG];
  logic        rd_ready;

  assign idx     = avs_address_i[7:2];
  assign aligned = (avs_address_i[1:0] == 2'h0);

  always_comb begin
    hit = '0;
    if (aligned) begin
      unique case (idx)
        `ACR_IDX_CFG:     hit[0] = 1'b1;
        `ACR_IDX_OFS_UP:  hit[1] = 1'b1;
        `ACR_IDX_OFS_LO:  hit[2] = 1'b1;
        `ACR_IDX_GAIN_UP: hit[3] = 1'b1;
        `ACR_IDX_GAIN_LO: hit[4] = 1'b1;
        default:          hit = '0;
      endcase
    end
  end

  // ==================================================
  // storage; masks drop reserved writes
  localparam logic [15:0] RSTS  [NREG] = '{`ACR_RST_CFG, `ACR_RST_OFS_UP, `ACR_RST_OFS_LO,
                                           `ACR_RST_GAIN_UP, `ACR_RST_GAIN_LO};
  localparam logic [15:0] MASKS [NREG] = '{`ACR_MASK_CFG, `ACR_MASK_UP, `ACR_MASK_LO,
                                           `ACR_MASK_UP, `ACR_MASK_LO};

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      acr_word_reg #(
        .RST  (RSTS[gi]),
        .MASK (MASKS[gi])
      ) u_reg (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .we_i      (avs_write_i && hit[gi]),
        .be_i      (avs_byteenable_i[1:0]),
        .wdata_i   (avs_writedata_i[15:0]),
        .q_o       (q[gi])
      );
    end
  endgenerate

  // ==================================================
  // read path: registered data, one wait cycle on reads
  acr_reg_wait u_wait (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .read_i     (avs_read_i),
    .rd_ready_o (rd_ready)
  );

  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (avs_read_i && !rd_ready) begin
      rdata_next = 32'h0000_0000; // unmapped reads zero
      for (int i = 0; i < NREG; i++) begin
        if (hit[i]) begin
          rdata_next = {16'h0000, q[i]};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = avs_read_i && !rd_ready;

  // ==================================================
  // channel outputs, straight from flip-flops except the highpass enable, which is gated by the global setting
  assign chan_cfg_o.chan_phase_trim =
    q[0][`ACR_CFG_PHASE_MSB:`ACR_CFG_PHASE_LSB];
  assign chan_cfg_o.chan_highpass_override = q[0][`ACR_CFG_HPO_BIT];
  assign chan_cfg_o.chan_input_select =
    acr_sel_t'(q[0][`ACR_CFG_SEL_MSB:`ACR_CFG_SEL_LSB]);
  // global setting is a level, so the enable is simple gating
  assign chan_highpass_en_o = global_highpass_setting_i && !q[0][`ACR_CFG_HPO_BIT];
  assign chan_cal_o.offset  = {q[1], q[2][15:8]};
  assign chan_cal_o.gain    = {q[3], q[4][15:8]};

  // ==================================================
  // checks
  sequence s_cfg_write;
    avs_write_i && hit[0];
  endsequence

  a_cfg_reserved : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_cfg_write |=> q[0][5:3] == 3'h0) else $error("cfg reserved bits set");
  a_lower_reserved : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    q[2][7:0] == 8'h00 && q[4][7:0] == 8'h00) else $error("low byte set");
  a_write_ignored : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    avs_write_i && hit[2] && avs_byteenable_i[0] |=> q[2][7:0] == 8'h00)
    else $error("reserved write kept");
  a_gain_reset : assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> q[3] == 16'h8000) else $error("gain reset wrong");
  a_cfg_reset : assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> q[0] == 16'h0000 && q[1] == 16'h0000) else $error("reset wrong");
  a_lower_reset : assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> q[2] == 16'h0000 && q[4] == 16'h0000) else $error("low reset");
  a_ofs_join : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    avs_write_i && hit[1] && (&avs_byteenable_i[1:0]) |=>
    chan_cal_o.offset[23:8] == $past(avs_writedata_i[15:0])) else $error("offset join");
  a_gain_join : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    avs_write_i && hit[4] && avs_byteenable_i[1] |=>
    chan_cal_o.gain[7:0] == $past(avs_writedata_i[15:8])) else $error("gain join");
  a_read_answer : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    avs_read_i && avs_waitrequest_o |=> !avs_read_i || !avs_waitrequest_o)
    else $error("read not answered");
  a_hp_override : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    chan_cfg_o.chan_highpass_override |-> !chan_highpass_en_o) else $error("hp on");

endmodule : acr_chan_regs

// [src/acr_pkg.sv]
package acr_pkg;

  typedef enum logic [1:0] {
    ACR_SEL_PINS    = 2'h0,
    ACR_SEL_SHORTED = 2'h1,
    ACR_SEL_TEST_P  = 2'h2,
    ACR_SEL_TEST_N  = 2'h3
  } acr_sel_t;

  typedef struct packed {
    logic [9:0] chan_phase_trim;
    logic       chan_highpass_override;
    acr_sel_t   chan_input_select;
  } acr_cfg_t;

  typedef struct packed {
    logic signed [23:0] offset;
    logic        [23:0] gain;
  } acr_cal_t;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } acr_avl_req_t;

endpackage : acr_pkg

// [src/acr_reg_wait.sv]
`timescale 1ns/1ps
`include "acr_regs_map.svh"

// read wait-state generator: read data are registered, so one wait cycle
module acr_reg_wait
  import acr_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // request
  input  wire logic read_i,
  // answer
  output logic      rd_ready_o
);

  logic rd_ready_reg;
  logic rd_ready_next;

  always_comb begin
    rd_ready_next = read_i && !rd_ready_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_ready_reg <= 1'b0;
    end else begin
      rd_ready_reg <= rd_ready_next;
    end
  end

  assign rd_ready_o = rd_ready_reg;

endmodule : acr_reg_wait

// [src/acr_regs_map.svh]
`ifndef ACR_REGS_MAP_SVH
`define ACR_REGS_MAP_SVH

// ==================================================
// register indices (byte address = index * 4)
`define ACR_IDX_CFG        6'h27
`define ACR_IDX_OFS_UP     6'h28
`define ACR_IDX_OFS_LO     6'h29
`define ACR_IDX_GAIN_UP    6'h2A
`define ACR_IDX_GAIN_LO    6'h2B

// ==================================================
// reset values
`define ACR_RST_CFG        16'h0000
`define ACR_RST_OFS_UP     16'h0000
`define ACR_RST_OFS_LO     16'h0000
`define ACR_RST_GAIN_UP    16'h8000
`define ACR_RST_GAIN_LO    16'h0000

// ==================================================
// field positions and writable masks
`define ACR_CFG_PHASE_MSB  15
`define ACR_CFG_PHASE_LSB  6
`define ACR_CFG_HPO_BIT    2
`define ACR_CFG_SEL_MSB    1
`define ACR_CFG_SEL_LSB    0
`define ACR_MASK_CFG       16'hFFC7
`define ACR_MASK_UP        16'hFFFF
`define ACR_MASK_LO        16'hFF00

// ==================================================
// bus timing
`define ACR_RD_WAIT        1

`endif

// [src/acr_word_reg.sv]
`timescale 1ns/1ps
`include "acr_regs_map.svh"

// one 16-bit register, only masked bits storable
module acr_word_reg
  import acr_pkg::*;
#(
  parameter logic [15:0] RST  = 16'h0000,
  parameter logic [15:0] MASK = 16'hFFFF
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // write port
  input  wire logic        we_i,
  input  wire logic [1:0]  be_i,
  input  wire logic [15:0] wdata_i,
  // stored value
  output logic      [15:0] q_o
);

  logic [15:0] q_reg;
  logic [15:0] q_next;

  always_comb begin
    q_next = q_reg;
    if (we_i) begin
      if (be_i[0]) begin
        q_next[7:0] = wdata_i[7:0] & MASK[7:0];
      end
      if (be_i[1]) begin
        q_next[15:8] = wdata_i[15:8] & MASK[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_reg <= RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;

  a_mask_holds_zero : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (q_reg & ~MASK) == 16'h0000) else $error("reserved bit stored");

endmodule : acr_word_reg
